// ===== ieoe_expander.sv
/*
 * Serial-bus slave port expander driving eight push-pull outputs.
 * Assumes SCL, SDA, bus-clear, select pins and pin readback are asynchronous
 * and far slower than clk; SDA is open drain, resolved outside.
 */
//
// Overview of operation
// - Address is 101 plus two bits from each select input's connection.
// - Upper four outputs default from high select, lower four from low select.
// - Ground connection gives default 0; supply, SCL or SDA give 1.
// - Bus-clear low resets the serial logic, abandoning any transfer.
// - While bus-clear is low, the protocol sits idle as after STOP.
// - Bus-clear never touches the output latch.
// - Reads return real pin levels, not latch contents.
// - Idle interface enters standby by itself, leaves on a START.
// - Each written data byte replaces all eight outputs at once.
// - Pins are sampled during address ack and each later ack of a read.
// - Select connections are re-decoded on every transmission.
// - Before the first transmission, SCL or SDA ties count as supply.
`timescale 1ns/1ps
module ieoe_expander
  import ieoe_pkg::*;
#(
  parameter int PORT_WIDTH = PORT_W
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic bus_clear_n,
  input wire logic addr_sel_high,
  input wire logic addr_sel_low,
  input wire logic [PORT_WIDTH-1:0] out_pin_in,
  output logic [PORT_WIDTH-1:0] out_port,
  output logic standby
);
  localparam int SYNC_W = PORT_WIDTH + 5;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic scl_s;
  logic sda_s;
  logic clr_n_s;
  logic sel_hi_s;
  logic sel_lo_s;
  logic [PORT_WIDTH-1:0] pins_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  ieoe_state_e state;
  logic [3:0] bit_cnt;
  logic [ADDR_W-1:0] shreg;
  logic [PORT_WIDTH-1:0] tx;
  logic rw;
  logic ack_phase;
  logic wr_stb;
  logic [PORT_WIDTH-1:0] wr_data;
  logic [ADDR_W-1:0] my_addr;
  logic [1:0] settle;

  ieoe_sel_if sel_h ();
  ieoe_sel_if sel_l ();

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Bus lines start at their idle level so no false edge follows reset
      sync1 <= {BUS_IDLE, {(SYNC_W-3){1'b0}}};
      sync2 <= {BUS_IDLE, {(SYNC_W-3){1'b0}}};
    end else if (ce) begin
      sync1 <= {scl_in, sda_in, bus_clear_n, addr_sel_high, addr_sel_low, out_pin_in};
      sync2 <= sync1;
    end
  end

  assign {scl_s, sda_s, clr_n_s, sel_hi_s, sel_lo_s, pins_s} = sync2;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // Classifier strobes: clear at START, watch the address bits, decide at the 7th
  always_comb begin
    sel_h.clr = start_cond;
    sel_h.track = (state == ST_ADDR) && (bit_cnt < BIT_LAST);
    sel_h.commit = (state == ST_ADDR) && scl_rise && (bit_cnt == BIT_LAST - 4'h1);
    sel_h.pin = sel_hi_s;
    sel_h.scl = scl_s;
    sel_h.sda = sda_s;
    sel_l.clr = sel_h.clr;
    sel_l.track = sel_h.track;
    sel_l.commit = sel_h.commit;
    sel_l.pin = sel_lo_s;
    sel_l.scl = scl_s;
    sel_l.sda = sda_s;
  end

  ieoe_sel_class u_sel_high (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .sel(sel_h.classifier)
  );

  ieoe_sel_class u_sel_low (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .sel(sel_l.classifier)
  );

  assign my_addr = {ADDR_FIXED, ieoe_high_bits(sel_h.code), ieoe_low_bits(sel_l.code)};

  // Protocol engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      shreg <= '0;
      tx <= '0;
      rw <= 1'b0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= '0;
    end else if (ce) begin
      wr_stb <= 1'b0;
      if (!clr_n_s) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        bit_cnt <= '0;
        ack_phase <= 1'b0;
      end else if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= '0;
        sda_oe <= 1'b0;
        ack_phase <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[ADDR_W-2:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == BIT_LAST) begin
                if (shreg == my_addr) begin
                  rw <= sda_s;
                  state <= ST_ACK;
                  ack_phase <= 1'b0;
                end else begin
                  state <= ST_IGNORE;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall && !ack_phase) begin
              sda_oe <= 1'b1;
              ack_phase <= 1'b1;
            end else if (scl_rise && ack_phase && rw) begin
              tx <= pins_s;
            end else if (scl_fall && ack_phase) begin
              ack_phase <= 1'b0;
              bit_cnt <= '0;
              if (rw) begin
                sda_oe <= ~tx[PORT_WIDTH-1];
                state <= ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[ADDR_W-2:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == BIT_LAST) begin
                wr_data <= {shreg, sda_s};
                wr_stb <= 1'b1;
                state <= ST_ACK;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              tx <= {tx[PORT_WIDTH-2:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == BITS_BYTE) begin
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
                state <= ST_RACK;
              end else begin
                sda_oe <= ~tx[PORT_WIDTH-1];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ack_phase <= ~sda_s;
              tx <= pins_s;
            end else if (scl_fall) begin
              bit_cnt <= '0;
              if (ack_phase) begin
                sda_oe <= ~tx[PORT_WIDTH-1];
                state <= ST_RDATA;
              end else begin
                state <= ST_IGNORE;
              end
              ack_phase <= 1'b0;
            end
          end
          ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  // Output latch: power-up defaults once the pin synchronisers have settled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_port <= OUT_RESET;
      settle <= '0;
    end else if (ce) begin
      if (settle != SETTLE_CYCLES) begin
        settle <= settle + 2'h1;
        if (settle == SETTLE_CYCLES - 2'h1) begin
          out_port <= {ieoe_group_default(sel_h.code), ieoe_group_default(sel_l.code)};
        end
      end else if (wr_stb) begin
        out_port <= wr_data;
      end
    end
  end

  // Standby whenever the engine is in ST_IDLE, from STOP or bus clear until the next START
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standby <= 1'b1;
    end else if (ce) begin
      standby <= (state == ST_IDLE) && !(start_cond && clr_n_s);
    end
  end
endmodule : ieoe_expander

// ===== ieoe_pkg.sv
/*
 * Constants and types shared by the eight-output serial port expander.
 * Assumes a single 25 MHz system clock domain; all pins arrive asynchronous.
 */
package ieoe_pkg;
  localparam int ADDR_W = 7;
  localparam int PORT_W = 8;
  localparam logic [2:0] ADDR_FIXED = 3'h5;
  localparam logic [PORT_W-1:0] OUT_RESET = 8'h00;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // SCL, SDA and bus-clear levels at rest
  localparam logic [2:0] BUS_IDLE = 3'h7;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [1:0] {
    SEL_GND,
    SEL_SUP,
    SEL_SCL,
    SEL_SDA
  } ieoe_sel_e;

  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WDATA,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } ieoe_state_e;

  function automatic logic [1:0] ieoe_high_bits(input ieoe_sel_e s);
    case (s)
      SEL_SCL: ieoe_high_bits = 2'h0;
      SEL_SDA: ieoe_high_bits = 2'h1;
      SEL_GND: ieoe_high_bits = 2'h2;
      default: ieoe_high_bits = 2'h3;
    endcase
  endfunction : ieoe_high_bits

  function automatic logic [1:0] ieoe_low_bits(input ieoe_sel_e s);
    case (s)
      SEL_GND: ieoe_low_bits = 2'h0;
      SEL_SUP: ieoe_low_bits = 2'h1;
      SEL_SCL: ieoe_low_bits = 2'h2;
      default: ieoe_low_bits = 2'h3;
    endcase
  endfunction : ieoe_low_bits

  function automatic logic [3:0] ieoe_group_default(input ieoe_sel_e s);
    ieoe_group_default = (s == SEL_GND) ? 4'h0 : 4'hF;
  endfunction : ieoe_group_default
endpackage : ieoe_pkg

// ===== ieoe_sel_if.sv
/*
 * Carrier between the protocol engine and one address-select classifier.
 * Assumes all levels here are already synchronised to clk.
 */
`timescale 1ns/1ps
interface ieoe_sel_if;
  import ieoe_pkg::*;
  logic clr;
  logic track;
  logic commit;
  logic pin;
  logic scl;
  logic sda;
  ieoe_sel_e code;
  modport engine (output clr, output track, output commit, output pin, output scl,
    output sda, input code);
  modport classifier (input clr, input track, input commit, input pin, input scl,
    input sda, output code);
endinterface : ieoe_sel_if

// ===== ieoe_sel_class.sv
/*
 * Classifies one address-select pin as ground, supply, SCL or SDA by
 * watching it against the bus lines through an address phase.
 * Assumes synchronised inputs and strobes from the protocol engine.
 */
`timescale 1ns/1ps
module ieoe_sel_class
  import ieoe_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  ieoe_sel_if.classifier sel
);
  logic ne_scl;
  logic ne_sda;
  logic seen_hi;
  logic seen_lo;
  logic decoded;
  ieoe_sel_e held;
  ieoe_sel_e next_held;

  always_comb begin
    if (!ne_scl) begin
      next_held = SEL_SCL;
    end else if (!ne_sda) begin
      next_held = SEL_SDA;
    end else if (seen_lo && !seen_hi) begin
      next_held = SEL_GND;
    end else begin
      next_held = SEL_SUP;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ne_scl <= 1'b0;
      ne_sda <= 1'b0;
      seen_hi <= 1'b0;
      seen_lo <= 1'b0;
    end else if (ce) begin
      if (sel.clr) begin
        ne_scl <= 1'b0;
        ne_sda <= 1'b0;
        seen_hi <= 1'b0;
        seen_lo <= 1'b0;
      end else if (sel.track) begin
        ne_scl <= ne_scl | (sel.pin != sel.scl);
        ne_sda <= ne_sda | (sel.pin != sel.sda);
        seen_hi <= seen_hi | sel.pin;
        seen_lo <= seen_lo | ~sel.pin;
      end
    end
  end

  // Re-decoded on every transmission, whoever it addresses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held <= SEL_SUP;
      decoded <= 1'b0;
    end else if (ce && sel.commit) begin
      held <= next_held;
      decoded <= 1'b1;
    end
  end

  // Before the first transmission a bus-tied pin looks like supply
  assign sel.code = decoded ? held : (sel.pin ? SEL_SUP : SEL_GND);
endmodule : ieoe_sel_class

// ===== ieoe_expander_monitor.sv
/* Checker on the expander top ports.
   Assumes it is bound into every ieoe_expander instance. */
`timescale 1ns/1ps
module ieoe_expander_monitor
  import ieoe_pkg::*;
#(parameter int PORT_WIDTH = PORT_W)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic bus_clear_n,
  input wire logic addr_sel_high,
  input wire logic addr_sel_low,
  input wire logic [PORT_WIDTH-1:0] out_pin_in,
  input wire logic [PORT_WIDTH-1:0] out_port,
  input wire logic standby
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence clr_held; !bus_clear_n [*6]; endsequence
  sequence bus_up; bus_clear_n [*6]; endsequence
  sequence scl_high; scl_in [*3]; endsequence
  AST_CLR_NO_DRIVE: assert property (clr_held |-> !sda_oe)
    else $error("sda driven in bus clear");
  AST_CLR_STANDBY: assert property (clr_held |-> standby)
    else $error("not idle in bus clear");
  AST_CLR_LATCH: assert property (clr_held |-> $stable(out_port))
    else $error("latch moved in bus clear");
  AST_CLR_ABANDON: assert property ($rose(bus_clear_n) |-> !sda_oe [*8])
    else $error("drive after bus clear");
  AST_STOP_IDLE: assert property (scl_in && $rose(sda_in) |-> ##[1:6] standby)
    else $error("no standby after stop");
  AST_START_WAKE: assert property (bus_up ##0 (scl_in && $fell(sda_in)) |-> ##[2:6] !standby)
    else $error("start did not wake");
  AST_POWERUP: assert property ($rose(resetn) |->
    ##[1:4] out_port == {{4{addr_sel_high}}, {4{addr_sel_low}}})
    else $error("wrong power-up levels");
  AST_HIGH_STABLE: assert property (bus_up ##0 scl_high |-> $stable(sda_oe))
    else $error("sda moved while scl high");
endmodule : ieoe_expander_monitor
bind ieoe_expander ieoe_expander_monitor #(.PORT_WIDTH(PORT_WIDTH)) u_mon (.*);

// ===== ieoe_i2c_master.sv
/* Bus master model: SCL and open-drain SDA, 320 ns per bit.
   Assumes the bench resolves SDA with a pull-up and feeds it back. */
`timescale 1ns/1ps
module ieoe_i2c_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  localparam time Q = 80;
  // Lines rest released; SCL stands still outside frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start;
    sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask : stop
  // Data moves only while SCL is low
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : bitx
  // MSB first; bit 0 is the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
  endtask : xfer
endmodule : ieoe_i2c_master

// ===== ieoe_expander_tb_top.sv
/* Self-checking bench for the expander with a bus master model.
   Assumes a 25 MHz clk; select pins strapped by the bench. */
`timescale 1ns/1ps
module ieoe_expander_tb_top;
  import ieoe_pkg::*;
  typedef struct {ieoe_sel_e h; ieoe_sel_e l; logic [6:0] a; logic [7:0] d;
    logic [7:0] m;} ieoe_row_s;
  logic clk, resetn, bus_clear_n, sda_oe, sda_out, standby, scl, sda_m, sel_h, sel_l;
  wire logic sda;
  logic [7:0] out_port, frc;
  logic [8:0] rx;
  ieoe_sel_e hs, ls;
  int failures, tests_run;
  ieoe_row_s rows [4] = '{'{SEL_GND, SEL_SDA, 7'h5B, 8'hA5, 8'h0F},
    '{SEL_SUP, SEL_SCL, 7'h5E, 8'h3C, 8'hFF}, '{SEL_SCL, SEL_GND, 7'h50, 8'h81, 8'h10},
    '{SEL_SDA, SEL_SUP, 7'h55, 8'h7E, 8'h80}};
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  assign sel_h = hs == SEL_GND ? 1'b0 : hs == SEL_SUP ? 1'b1 : hs == SEL_SCL ? scl : sda;
  assign sel_l = ls == SEL_GND ? 1'b0 : ls == SEL_SUP ? 1'b1 : ls == SEL_SCL ? scl : sda;
  ieoe_expander DUT (.clk(clk), .resetn(resetn), .ce(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .bus_clear_n(bus_clear_n), .addr_sel_high(sel_h),
    .addr_sel_low(sel_l), .out_pin_in(out_port ^ frc), .out_port(out_port),
    .standby(standby));
  ieoe_i2c_master M (.scl(scl), .sda_m(sda_m), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic final_report;
    $display("tests %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    resetn = 0;
    bus_clear_n = 1;
    frc = 0;
    hs = SEL_SDA;
    ls = SEL_GND;
    failures = 0;
    tests_run = 0;
    cyc(3);
    resetn = 1;
    cyc(6);
    chk(out_port, 8'hF0, "power-up");
    $display("test power-up done");
    foreach (rows[i]) begin
      cyc(1);
      hs = rows[i].h;
      ls = rows[i].l;
      M.start();
      M.xfer({rows[i].a, 2'b01}, rx);
      chk(rx[0], 8'h00, "addr ack");
      M.xfer({rows[i].d, 1'b1}, rx);
      chk(out_port, rows[i].d, "byte 1");
      M.xfer({~rows[i].d, 1'b1}, rx);
      chk(out_port, ~rows[i].d, "byte 2");
      M.stop();
      cyc(4);
      chk(standby, 8'h01, "standby");
      frc = rows[i].m;
      M.start();
      M.xfer({rows[i].a, 2'b11}, rx);
      frc = 0;
      M.xfer(9'h1FE, rx);
      chk(rx[8:1], ~rows[i].d ^ rows[i].m, "read pins");
      M.xfer(9'h1FF, rx);
      chk(rx[8:1], ~rows[i].d, "resample");
      M.stop();
      $display("test row %0d done", i);
    end
    cyc(1);
    hs = SEL_GND;
    ls = SEL_GND;
    M.start();
    M.xfer({7'h59, 2'b01}, rx);
    chk(rx[0], 8'h01, "foreign addr");
    M.xfer(9'h001, rx);
    chk(rx[0], 8'h01, "stay passive");
    chk(out_port, 8'h81, "latch kept");
    M.stop();
    $display("test mismatch done");
    M.start();
    M.xfer({7'h58, 2'b11}, rx);
    M.bitx(1'b1, rx[8]);
    chk(rx[8], 8'h01, "first read bit");
    cyc(2);
    chk(standby, 8'h00, "busy");
    chk(sda_oe, 8'h01, "read drive");
    chk(sda_out, 8'h00, "drive level");
    bus_clear_n = 0;
    cyc(8);
    chk(standby, 8'h01, "clear idle");
    chk(sda_oe, 8'h00, "clear release");
    bus_clear_n = 1;
    M.stop();
    chk(out_port, 8'h81, "clear keeps latch");
    M.start();
    M.xfer({7'h58, 2'b01}, rx);
    M.xfer({8'h5A, 1'b1}, rx);
    chk(out_port, 8'h5A, "after clear");
    M.stop();
    $display("test bus clear done");
    cyc(1);
    ls = SEL_SCL;
    resetn = 0;
    cyc(2);
    resetn = 1;
    cyc(6);
    chk(out_port, 8'h0F, "second reset");
    $display("test second reset done");
    final_report();
  end
endmodule : ieoe_expander_tb_top
